// ==== pkg/tmrb_pkg.sv ====
// Purpose: Shared constants and types of the basic 16-bit timer/counter.
// Assumes: APB slave with 32-bit data and a 12-bit byte address.
// Notes: Control fields keep their documented bit positions.
package tmrb_pkg;

	localparam int TMRB_ADDR_W = 12;
	localparam int TMRB_CNT_W = 16;
	localparam int TMRB_PRE_W = 8;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [TMRB_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} tmrb_apb_req_s;

	typedef struct packed {
		logic run_enable;
		logic idle_stop;
		logic [1:0] extended_source_select;
		logic gate_accumulate_enable;
		logic [1:0] prescale_select;
		logic external_sync_select;
		logic clock_source_select;
	} tmrb_ctrl_s;

	// Register byte addresses.
	localparam logic [TMRB_ADDR_W-1:0] TMRB_OFS_CONTROL = 12'h000;
	localparam logic [TMRB_ADDR_W-1:0] TMRB_OFS_PERIOD = 12'h004;
	localparam logic [TMRB_ADDR_W-1:0] TMRB_OFS_COUNT = 12'h008;
	localparam logic [TMRB_ADDR_W-1:0] TMRB_OFS_INT_STATUS = 12'h00c;
	localparam logic [TMRB_ADDR_W-1:0] TMRB_OFS_INT_CLEAR = 12'h010;
	localparam logic [TMRB_ADDR_W-1:0] TMRB_OFS_INT_ENABLE = 12'h014;

	// Control field positions, implemented mask and reset value.
	localparam int TMRB_RUN_BIT = 15;
	localparam int TMRB_IDLE_BIT = 13;
	localparam int TMRB_ECS_LSB = 8;
	localparam int TMRB_GATE_BIT = 6;
	localparam int TMRB_PRE_LSB = 4;
	localparam int TMRB_SYNC_BIT = 2;
	localparam int TMRB_CS_BIT = 1;
	localparam logic [15:0] TMRB_CTRL_MASK = 16'ha376;
	localparam logic [15:0] TMRB_CTRL_RESET = 16'h0000;
	localparam logic [TMRB_CNT_W-1:0] TMRB_PERIOD_RESET = 16'hffff;

	// Extended source codes.
	localparam logic [1:0] TMRB_ECS_GENERIC = 2'b11;
	localparam logic [1:0] TMRB_ECS_LOW_POWER_RC_OSCILLATOR = 2'b10;
	localparam logic [1:0] TMRB_ECS_DEDICATED = 2'b01;
	localparam logic [1:0] TMRB_ECS_SECONDARY_OSCILLATOR = 2'b00;

	// Prescale codes and terminal counts (ratio minus one).
	localparam logic [1:0] TMRB_PRE_256 = 2'b11;
	localparam logic [1:0] TMRB_PRE_64 = 2'b10;
	localparam logic [1:0] TMRB_PRE_8 = 2'b01;
	localparam logic [TMRB_PRE_W-1:0] TMRB_LIM_256 = 8'hff;
	localparam logic [TMRB_PRE_W-1:0] TMRB_LIM_64 = 8'h3f;
	localparam logic [TMRB_PRE_W-1:0] TMRB_LIM_8 = 8'h07;
	localparam logic [TMRB_PRE_W-1:0] TMRB_LIM_1 = 8'h00;

	// Indices of the pins passed through the input synchroniser.
	localparam int TMRB_PIN_GENERIC = 0;
	localparam int TMRB_PIN_DEDICATED = 1;
	localparam int TMRB_PIN_SECONDARY_OSCILLATOR = 2;
	localparam int TMRB_PIN_LOW_POWER_RC_OSCILLATOR = 3;
	localparam int TMRB_PIN_GATE = 4;
	localparam int TMRB_PIN_W = 5;

	// Interrupt status layout.
	localparam int TMRB_STAT_MATCH = 0;
	localparam int TMRB_STAT_GATE = 1;
	localparam int TMRB_STAT_W = 2;

endpackage

// ==== hw/tmrb_pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter and edge pulses.
// Assumes: Inputs are asynchronous to clk_i.
// Notes: A change is accepted once the second and third stages agree.
`timescale 1ns/1ps
module tmrb_pin_sync #(
	parameter int WIDTH = 5
) (
	input wire logic clk_i, // System clock.
	input wire logic reset_n_i, // Asynchronous reset, active low.
	input wire logic [WIDTH-1:0] async_i, // Raw inputs.
	output logic [WIDTH-1:0] level_o, // Filtered level.
	output logic [WIDTH-1:0] rise_o, // One-cycle pulse on a rising edge.
	output logic [WIDTH-1:0] fall_o // One-cycle pulse on a falling edge.
);
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
				end else begin
					s1 <= async_i[gi];
					s2 <= s1;
					s3 <= s2;
				end
			end
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					level_o[gi] <= 1'b0;
					rise_o[gi] <= 1'b0;
					fall_o[gi] <= 1'b0;
				end else begin
					rise_o[gi] <= (s2 == s3) && s3 && !level_o[gi];
					fall_o[gi] <= (s2 == s3) && !s3 && level_o[gi];
					if (s2 == s3) begin
						level_o[gi] <= s3;
					end
				end
			end
		end
	endgenerate
endmodule

// ==== hw/tmrb_timer.sv ====
// Purpose: Basic 16-bit timer/counter with period match and gated accumulation.
// Assumes: clk_i is the oscillator clock; the internal source runs at half of it.
// Notes: Registers are reached over APB; every external source is synchronised.
// Overview of operation
// RULE_01: Timer, synchronous counter and unsynchronised counter modes.
// RULE_02: Interrupt on period match or gate fall.
// RULE_03: Run bit 15 starts and stops counting.
// RULE_04: Idle-stop bit 13 halts module in Idle; the code halts only counting, and a gate fall still sets its flag.
// RULE_05: Bits 9-8 pick the external source.
// RULE_06: Gate bit 6 applies only to internal clock.
// RULE_07: Prescaler divides by 1, 8, 64, 256.
// RULE_08: Bit 2 picks synchronised external counting.
// RULE_09: Bit 1 picks external or internal half clock.
// RULE_10: Control write while running clears the prescaler.
// RULE_11: Unimplemented control bits read as zero.
// RULE_12: Power-on reset clears all control bits.
// RULE_13: Software sets run, prescale, source, period, interrupts.
// RULE_14: Serves as time base or interval timer.
// RULE_15: Can keep counting during Idle or Sleep.
// RULE_16: Tick increments; match wraps to zero, flags.
// RULE_17: Gated mode counts while gate high, flags fall.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module tmrb_timer
	import tmrb_pkg::*;
(
	input wire logic clk_i, // Oscillator clock, 100 MHz.
	input wire logic reset_n_i, // Asynchronous power-on reset, active low.
	input wire tmrb_pkg::tmrb_apb_req_s apb_i, // APB request signals.
	output logic [31:0] prdata_o, // APB read data.
	output logic pready_o, // APB ready.
	output logic pslverr_o, // APB error on an unmapped address.
	input wire logic idle_i, // Device is in Idle mode.
	input wire logic sleep_i, // Device is in Sleep mode.
	input wire logic generic_external_timer_input_i, // Generic external timer input.
	input wire logic dedicated_external_clock_pin_i, // Dedicated external clock pin.
	input wire logic secondary_oscillator_i, // Secondary oscillator.
	input wire logic low_power_rc_oscillator_i, // Low-power RC oscillator.
	input wire logic gate_i, // External gate for accumulation.
	output logic irq_o, // Level interrupt, high while an enabled flag is set.
	output logic match_pulse_o // One-cycle pulse on each period match.
);
	logic [15:0] control;
	tmrb_ctrl_s ctrl;
	logic [TMRB_CNT_W-1:0] period_register;
	logic [TMRB_CNT_W-1:0] count;
	logic [TMRB_PRE_W-1:0] pre_cnt;
	logic [TMRB_PRE_W-1:0] pre_lim;
	logic [TMRB_STAT_W-1:0] int_status;
	logic [TMRB_STAT_W-1:0] int_enable;
	logic [TMRB_STAT_W-1:0] int_set;
	logic [TMRB_STAT_W-1:0] int_clr;
	logic [TMRB_PIN_W-1:0] pin_raw;
	logic [TMRB_PIN_W-1:0] pin_level;
	logic [TMRB_PIN_W-1:0] pin_rise;
	logic [TMRB_PIN_W-1:0] pin_fall;
	logic div_phase;
	logic access;
	logic commit;
	logic wr;
	logic ctrl_wr;
	logic [31:0] next_prdata;
	logic next_err;
	logic active;
	logic gated;
	logic ext_edge;
	logic src_edge;
	logic tick;
	logic at_match;

	assign ctrl.run_enable = control[TMRB_RUN_BIT];
	assign ctrl.idle_stop = control[TMRB_IDLE_BIT];
	assign ctrl.extended_source_select = control[TMRB_ECS_LSB+1:TMRB_ECS_LSB];
	assign ctrl.gate_accumulate_enable = control[TMRB_GATE_BIT];
	assign ctrl.prescale_select = control[TMRB_PRE_LSB+1:TMRB_PRE_LSB];
	assign ctrl.external_sync_select = control[TMRB_SYNC_BIT];
	assign ctrl.clock_source_select = control[TMRB_CS_BIT];

	// APB slave: one wait cycle, then a registered answer.
	assign access = apb_i.psel && apb_i.penable;
	assign commit = access && pready_o;
	assign wr = commit && apb_i.pwrite;
	assign ctrl_wr = wr && (apb_i.paddr == TMRB_OFS_CONTROL);

	always_comb begin
		next_prdata = 32'h0000_0000;
		next_err = 1'b0;
		if (apb_i.paddr == TMRB_OFS_CONTROL) begin
			next_prdata = {16'h0000, control & TMRB_CTRL_MASK}; // [RULE_11]
		end else if (apb_i.paddr == TMRB_OFS_PERIOD) begin
			next_prdata = {16'h0000, period_register};
		end else if (apb_i.paddr == TMRB_OFS_COUNT) begin
			next_prdata = {16'h0000, count};
		end else if (apb_i.paddr == TMRB_OFS_INT_STATUS) begin
			next_prdata = {30'h0000_0000, int_status};
		end else if (apb_i.paddr == TMRB_OFS_INT_CLEAR) begin
			next_prdata = 32'h0000_0000;
		end else if (apb_i.paddr == TMRB_OFS_INT_ENABLE) begin
			next_prdata = {30'h0000_0000, int_enable};
		end else begin
			next_err = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pready_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= access && !pready_o;
			if (access && !pready_o) begin
				prdata_o <= apb_i.pwrite ? 32'h0000_0000 : next_prdata;
				pslverr_o <= next_err;
			end else begin
				prdata_o <= 32'h0000_0000;
				pslverr_o <= 1'b0;
			end
		end
	end

	// Writable registers; unimplemented bits are never stored.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			control <= TMRB_CTRL_RESET; // [RULE_12]
			period_register <= TMRB_PERIOD_RESET;
			int_enable <= '0;
		end else if (wr) begin
			if (apb_i.paddr == TMRB_OFS_CONTROL) begin
				control <= apb_i.pwdata[15:0] & TMRB_CTRL_MASK; // [RULE_11] [RULE_13]
			end else if (apb_i.paddr == TMRB_OFS_PERIOD) begin
				period_register <= apb_i.pwdata[15:0];
			end else if (apb_i.paddr == TMRB_OFS_INT_ENABLE) begin
				int_enable <= apb_i.pwdata[TMRB_STAT_W-1:0];
			end
		end
	end

	// Every source comes from another clock, so all go through the synchroniser.
	assign pin_raw[TMRB_PIN_GENERIC] = generic_external_timer_input_i;
	assign pin_raw[TMRB_PIN_DEDICATED] = dedicated_external_clock_pin_i;
	assign pin_raw[TMRB_PIN_SECONDARY_OSCILLATOR] = secondary_oscillator_i;
	assign pin_raw[TMRB_PIN_LOW_POWER_RC_OSCILLATOR] = low_power_rc_oscillator_i;
	assign pin_raw[TMRB_PIN_GATE] = gate_i;

	tmrb_pin_sync #(
		.WIDTH(TMRB_PIN_W)
	) u_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.async_i(pin_raw),
		.level_o(pin_level),
		.rise_o(pin_rise),
		.fall_o(pin_fall)
	);

	// Internal source is half the oscillator rate: a pulse every other cycle.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_phase <= 1'b0;
		end else begin
			div_phase <= !div_phase; // [RULE_09]
		end
	end

	always_comb begin
		case (ctrl.extended_source_select) // [RULE_05]
			TMRB_ECS_GENERIC: ext_edge = pin_rise[TMRB_PIN_GENERIC];
			TMRB_ECS_LOW_POWER_RC_OSCILLATOR: ext_edge = pin_rise[TMRB_PIN_LOW_POWER_RC_OSCILLATOR];
			TMRB_ECS_DEDICATED: ext_edge = pin_rise[TMRB_PIN_DEDICATED];
			default: ext_edge = pin_rise[TMRB_PIN_SECONDARY_OSCILLATOR];
		endcase
	end

	always_comb begin
		case (ctrl.prescale_select) // [RULE_07]
			TMRB_PRE_256: pre_lim = TMRB_LIM_256;
			TMRB_PRE_64: pre_lim = TMRB_LIM_64;
			TMRB_PRE_8: pre_lim = TMRB_LIM_8;
			default: pre_lim = TMRB_LIM_1;
		endcase
	end

	// The system clock stops in Sleep, so only the unsynchronised counter keeps going.
	assign active = ctrl.run_enable && !(idle_i && ctrl.idle_stop); // [RULE_03] [RULE_04] [RULE_15]
	assign gated = !ctrl.clock_source_select && ctrl.gate_accumulate_enable; // [RULE_06]
	always_comb begin
		if (ctrl.clock_source_select) begin
			src_edge = active && ext_edge && (!sleep_i || !ctrl.external_sync_select); // [RULE_01] [RULE_08] [RULE_15]
		end else begin
			src_edge = active && div_phase && !sleep_i && (!gated || pin_level[TMRB_PIN_GATE]); // [RULE_01] [RULE_17]
		end
	end
	assign tick = src_edge && (pre_cnt == pre_lim);
	assign at_match = (count == period_register);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pre_cnt <= '0;
		end else if (ctrl_wr && ctrl.run_enable) begin
			pre_cnt <= '0; // [RULE_10]
		end else if (src_edge) begin
			pre_cnt <= (pre_cnt == pre_lim) ? '0 : pre_cnt + 8'h01; // [RULE_07]
		end
	end

	// A software write to the count wins over a tick in the same cycle.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count <= '0;
		end else if (wr && (apb_i.paddr == TMRB_OFS_COUNT)) begin
			count <= apb_i.pwdata[15:0];
		end else if (tick) begin
			count <= at_match ? '0 : count + 16'h0001; // [RULE_16] [RULE_14]
		end
	end

	// In gated mode the flag marks the end of a gate window, not each match.
	assign int_set[TMRB_STAT_MATCH] = tick && at_match && !gated; // [RULE_02] [RULE_16]
	assign int_set[TMRB_STAT_GATE] = gated && ctrl.run_enable && pin_fall[TMRB_PIN_GATE]; // [RULE_17]
	assign int_clr = (wr && (apb_i.paddr == TMRB_OFS_INT_CLEAR)) ?
		apb_i.pwdata[TMRB_STAT_W-1:0] : '0;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			int_status <= '0;
		end else begin
			int_status <= (int_status & ~int_clr) | int_set; // [RULE_02]
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_o <= 1'b0;
			match_pulse_o <= 1'b0;
		end else begin
			irq_o <= |(int_status & int_enable); // [RULE_02]
			match_pulse_o <= tick && at_match; // [RULE_14]
		end
	end

	a_reserved_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_11]
		(access && !pready_o && !apb_i.pwrite && apb_i.paddr == TMRB_OFS_CONTROL)
		|=> ((prdata_o[15:0] & ~TMRB_CTRL_MASK) == 16'h0000) && (prdata_o[31:16] == 16'h0000))
		else $error("Unimplemented control bits read nonzero.");

	a_stopped_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_03]
		(!ctrl.run_enable && !(wr && apb_i.paddr == TMRB_OFS_COUNT)) |=> $stable(count))
		else $error("Count moved while stopped.");

	a_match_wrap: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_16]
		(tick && at_match && !gated && !(wr && apb_i.paddr == TMRB_OFS_COUNT))
		|=> (count == 16'h0000) && int_status[TMRB_STAT_MATCH] && match_pulse_o)
		else $error("Period match did not wrap and flag.");

	a_prescale_ratio: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_07]
		tick |-> (ctrl.prescale_select != TMRB_PRE_256 || pre_cnt == 8'hff) &&
		(ctrl.prescale_select != TMRB_PRE_64 || pre_cnt == 8'h3f) &&
		(ctrl.prescale_select != TMRB_PRE_8 || pre_cnt == 8'h07) &&
		(ctrl.prescale_select != 2'b00 || pre_cnt == 8'h00))
		else $error("Tick at wrong prescale count.");

	a_idle_halt: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_04]
		(idle_i && ctrl.idle_stop) |-> !tick && !src_edge)
		else $error("Counting during Idle with idle stop set.");

	a_gate_fall: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_17]
		(gated && ctrl.run_enable && $fell(pin_level[TMRB_PIN_GATE])) |-> ##[0:1]
		int_status[TMRB_STAT_GATE])
		else $error("Gate fall did not set its flag.");

	a_gate_low: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_06]
		(gated && !pin_level[TMRB_PIN_GATE]) |-> !src_edge)
		else $error("Gated count advanced with gate low.");

	a_ctrl_wr_pre: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_10]
		(ctrl_wr && ctrl.run_enable) |=> (pre_cnt == 8'h00))
		else $error("Control write while running kept the prescaler.");

	a_irq_level: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_02]
		(int_status & int_enable) != '0 |=> irq_o)
		else $error("Enabled flag did not raise the interrupt.");

	a_sleep_sync: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_08]
		(sleep_i && (!ctrl.clock_source_select || ctrl.external_sync_select)) |-> !src_edge)
		else $error("Synchronised source counted in Sleep.");

	a_half_rate: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_09]
		(src_edge && !ctrl.clock_source_select) |=> !src_edge)
		else $error("Internal source faster than half the clock.");

	a_apb_answer: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(access && !pready_o) |=> pready_o ##1 !pready_o)
		else $error("APB answer not one cycle after access.");

	c_match: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		int_set[TMRB_STAT_MATCH]);
	c_gate_fall: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		int_set[TMRB_STAT_GATE]);
	c_ext_count: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		tick && ctrl.clock_source_select && !ctrl.external_sync_select && sleep_i);
	c_irq: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		$rose(irq_o));
endmodule

// ==== test/tmrb_tb.sv ====
// Purpose: Self-checking bench for the basic 16-bit timer/counter.
// Assumes: APB answers within a few cycles; pins stay high for six cycles and low for seven between pulses.
// Notes: Tick rates are measured between match pulses, so bus latency drops out.
`timescale 1ns/1ps
module tb;
	import tmrb_pkg::*;
	logic clk_i;
	logic reset_n_i;
	tmrb_apb_req_s apb_req;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic match_pulse;
	logic idle;
	logic sleep;
	logic gate;
	logic [3:0] ext_pins;
	logic [31:0] rdata;
	logic [15:0] held;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	int ival;
	int ratio [4] = '{1, 8, 64, 256};

	tmrb_timer u_dut (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.apb_i(apb_req),
		.prdata_o(prdata),
		.pready_o(pready),
		.pslverr_o(pslverr),
		.idle_i(idle),
		.sleep_i(sleep),
		.generic_external_timer_input_i(ext_pins[3]),
		.dedicated_external_clock_pin_i(ext_pins[1]),
		.secondary_oscillator_i(ext_pins[0]),
		.low_power_rc_oscillator_i(ext_pins[2]),
		.gate_i(gate),
		.irq_o(irq),
		.match_pulse_o(match_pulse)
	);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// A hung handshake must still end in the closing report.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			mismatches++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Waits for the answer as long as it takes; only the cycle ceiling ends a hang.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk_i);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready !== 1'b1);
		rdata = (pslverr === 1'b1) ? 32'hdead0000 | prdata : prdata;
		apb_req <= '0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(rdata, exp, what);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic wait_match();
		ival = 0;
		do begin
			@(posedge clk_i);
			ival++;
		end while (match_pulse !== 1'b1 && ival < 3000);
	endtask

	task automatic pulse(input int k, input int n);
		repeat (n) begin
			@(posedge clk_i);
			ext_pins[k] <= 1'b1;
			wait_cyc(6);
			ext_pins[k] <= 1'b0;
			wait_cyc(6);
		end
	endtask

	function automatic logic [31:0] ctrl(input logic run, input logic idl, input logic [1:0] ecs,
		input logic gt, input logic [1:0] pre, input logic syn, input logic cs);
		return {16'h0, run, 1'b0, idl, 3'b0, ecs, 1'b0, gt, pre, 1'b0, syn, cs, 1'b0};
	endfunction

	task automatic count_moved(input string what);
		apb(1'b0, TMRB_OFS_COUNT, 32'h0);
		chk({31'h0, rdata[15:0] != 16'h0}, 32'h1, what);
	endtask

	initial begin
		apb_req = '0;
		idle = 1'b0;
		sleep = 1'b0;
		gate = 1'b0;
		ext_pins = 4'h0;
		reset_n_i = 1'b0;
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(TMRB_OFS_CONTROL, 32'h0, "control reset");
		rd(TMRB_OFS_PERIOD, 32'hffff, "period reset");
		rd(TMRB_OFS_COUNT, 32'h0, "count reset");
		rd(TMRB_OFS_INT_STATUS, 32'h0, "status reset");
		rd(12'h020, 32'hdead0000, "unmapped read");
		apb(1'b1, 12'h020, 32'hffff);
		chk(rdata, 32'hdead0000, "unmapped write");
		wr(TMRB_OFS_CONTROL, 32'hffff);
		rd(TMRB_OFS_CONTROL, 32'h0000a376, "reserved bits");
		wr(TMRB_OFS_CONTROL, 32'h0);
		wr(TMRB_OFS_INT_STATUS, 32'h3);
		rd(TMRB_OFS_INT_STATUS, 32'h0, "status is read-only");
		// Each prescale code: ticks every two clocks times the ratio, match every period+1 ticks.
		wr(TMRB_OFS_PERIOD, 32'h3);
		wr(TMRB_OFS_INT_ENABLE, 32'h1);
		for (int c = 0; c < 4; c++) begin
			wr(TMRB_OFS_CONTROL, 32'h0);
			wr(TMRB_OFS_COUNT, 32'h0);
			wr(TMRB_OFS_CONTROL, ctrl(1'b1, 1'b0, 2'b00, 1'b0, c[1:0], 1'b0, 1'b0));
			wait_match();
			wait_match();
			chk(ival, 4 * ratio[c] * 2, "match interval");
			wait_cyc(2);
			chk({31'h0, irq}, 32'h1, "irq on match");
		end
		wr(TMRB_OFS_CONTROL, 32'h0);
		rd(TMRB_OFS_INT_STATUS, 32'h1, "match flag");
		wr(TMRB_OFS_INT_ENABLE, 32'h0);
		wait_cyc(2);
		chk({31'h0, irq}, 32'h0, "irq masked");
		wr(TMRB_OFS_INT_ENABLE, 32'h1);
		wait_cyc(2);
		chk({31'h0, irq}, 32'h1, "irq unmasked");
		wr(TMRB_OFS_INT_CLEAR, 32'h1);
		rd(TMRB_OFS_INT_CLEAR, 32'h0, "clear reads zero");
		rd(TMRB_OFS_INT_STATUS, 32'h0, "flag cleared");
		chk({31'h0, irq}, 32'h0, "irq cleared");
		// Rewrites closer than one 1:8 tick keep the prescaler from ever reaching it.
		wr(TMRB_OFS_PERIOD, 32'hffff);
		wr(TMRB_OFS_COUNT, 32'h0);
		repeat (20) wr(TMRB_OFS_CONTROL, ctrl(1'b1, 1'b0, 2'b00, 1'b0, 2'b01, 1'b0, 1'b0));
		rd(TMRB_OFS_COUNT, 32'h0, "prescaler cleared");
		wait_cyc(40);
		count_moved("counts after rewrites");
		wr(TMRB_OFS_CONTROL, 32'h0);
		wr(TMRB_OFS_COUNT, 32'h0);
		wait_cyc(40);
		rd(TMRB_OFS_COUNT, 32'h0, "stopped");
		idle <= 1'b1;
		wr(TMRB_OFS_CONTROL, ctrl(1'b1, 1'b1, 2'b00, 1'b0, 2'b00, 1'b0, 1'b0));
		wait_cyc(40);
		rd(TMRB_OFS_COUNT, 32'h0, "halted in idle");
		wr(TMRB_OFS_CONTROL, ctrl(1'b1, 1'b0, 2'b00, 1'b0, 2'b00, 1'b0, 1'b0));
		wait_cyc(20);
		count_moved("runs in idle");
		idle <= 1'b0;
		// Gated accumulation: counts only while the gate is high, flags its fall.
		wr(TMRB_OFS_CONTROL, 32'h0);
		wr(TMRB_OFS_COUNT, 32'h0);
		wr(TMRB_OFS_CONTROL, ctrl(1'b1, 1'b0, 2'b00, 1'b1, 2'b00, 1'b0, 1'b0));
		wait_cyc(40);
		rd(TMRB_OFS_COUNT, 32'h0, "gate low holds");
		gate <= 1'b1;
		wait_cyc(40);
		gate <= 1'b0;
		wait_cyc(20);
		apb(1'b0, TMRB_OFS_COUNT, 32'h0);
		held = rdata[15:0];
		chk({31'h0, held != 16'h0}, 32'h1, "gate high counts");
		rd(TMRB_OFS_INT_STATUS, 32'h2, "gate fall flag");
		wait_cyc(20);
		rd(TMRB_OFS_COUNT, {16'h0, held}, "count holds");
		wr(TMRB_OFS_INT_CLEAR, 32'h3);
		// Every external source with the gate bit set, which external clocking ignores.
		for (int k = 0; k < 4; k++) begin
			wr(TMRB_OFS_CONTROL, 32'h0);
			wr(TMRB_OFS_COUNT, 32'h0);
			wr(TMRB_OFS_CONTROL, ctrl(1'b1, 1'b0, k[1:0], 1'b1, 2'b00, 1'b1, 1'b1));
			pulse(k, 3);
			pulse((k + 1) % 4, 2);
			wait_cyc(8);
			rd(TMRB_OFS_COUNT, 32'h3, "external edges");
		end
		// In Sleep only the unsynchronised counter keeps running.
		sleep <= 1'b1;
		for (int s = 1; s >= 0; s--) begin
			wr(TMRB_OFS_CONTROL, 32'h0);
			wr(TMRB_OFS_COUNT, 32'h0);
			wr(TMRB_OFS_CONTROL, ctrl(1'b1, 1'b0, 2'b11, 1'b0, 2'b00, s[0], 1'b1));
			pulse(3, 3);
			wait_cyc(8);
			rd(TMRB_OFS_COUNT, s ? 32'h0 : 32'h3, "sleep counting");
		end
		sleep <= 1'b0;
		stop_test();
	end
endmodule
